// [shared/uefm_pkg.sv]
package uefm_pkg;
	localparam int NSLOT      = 16;
	localparam int SW         = 4;
	localparam int BI         = 5;
	localparam int AW         = 12;
	localparam int LW         = 11;
	localparam int DW         = 8;
	localparam int PW         = 16;
	localparam int DEPTH      = 2462;
	localparam int CTRL_SLOTS = 2;

	// Slot 0 control receive, 1 control transmit, 2..15 endpoints 1..14
	localparam logic [SW-1:0] SLOT_CTRL_OUT = 4'h0;
	localparam logic [BI-1:0] CTRL_IN_BI    = 5'h02;

	// Endpoint configuration layout
	localparam int CW      = 8;
	localparam int CFG_EN  = 0;
	localparam int CFG_DIR = 1;
	localparam int CFG_ISO = 2;
	localparam int CFG_SZ  = 4;
	localparam int SZ_W    = 4;
	localparam logic [CW-1:0] CFG_RST      = 8'h00;
	localparam logic [CW-1:0] CTRL_OUT_CFG = 8'h31;
	localparam logic [CW-1:0] CTRL_IN_CFG  = 8'h33;

	// Register map, byte addresses
	localparam int RA_W    = 8;
	localparam int WIN_LSB = 6;
	localparam int SLOT_LSB = 2;
	localparam logic [1:0]      WIN_CFG   = 2'h0;
	localparam logic [1:0]      WIN_STAT  = 2'h2;
	localparam logic [RA_W-1:0] REG_IRQ   = 8'h40;
	localparam logic [RA_W-1:0] REG_CMD   = 8'h44;
	localparam logic [RA_W-1:0] REG_DATA  = 8'h48;
	localparam logic [RA_W-1:0] REG_ALLOC = 8'h4C;

	// Command word: op in [7:4], slot in [3:0]
	localparam int CMD_OP = 4;
	localparam logic [3:0] OP_READ  = 4'h1;
	localparam logic [3:0] OP_WRITE = 4'h2;
	localparam logic [3:0] OP_CLEAR = 4'h3;
	localparam logic [3:0] OP_VALID = 4'h4;
	localparam logic [3:0] OP_ACK   = 4'h5;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h1,
		S_RX     = 4'h2,
		S_TX_RD  = 4'h4,
		S_TX_OUT = 4'h8
	} uefm_state_e;

	// Logical buffer size; disabled or reserved gives zero
	function automatic logic [LW-1:0] uefm_size(input logic [CW-1:0] cfg);
		logic [SZ_W-1:0] code;
		code = cfg[CFG_SZ +: SZ_W];
		uefm_size = 11'h000;
		if (cfg[CFG_EN] && cfg[CFG_ISO]) begin
			case (code)
				4'h0: uefm_size = 11'h010;
				4'h1: uefm_size = 11'h020;
				4'h2: uefm_size = 11'h030;
				4'h3: uefm_size = 11'h040;
				4'h4: uefm_size = 11'h060;
				4'h5: uefm_size = 11'h080;
				4'h6: uefm_size = 11'h0A0;
				4'h7: uefm_size = 11'h0C0;
				4'h8: uefm_size = 11'h100;
				4'h9: uefm_size = 11'h140;
				4'hA: uefm_size = 11'h180;
				4'hB: uefm_size = 11'h200;
				4'hC: uefm_size = 11'h280;
				4'hD: uefm_size = 11'h300;
				4'hE: uefm_size = 11'h380;
				default: uefm_size = 11'h3FF;
			endcase
		end else if (cfg[CFG_EN]) begin
			case (code)
				4'h0: uefm_size = 11'h008;
				4'h1: uefm_size = 11'h010;
				4'h2: uefm_size = 11'h020;
				4'h3: uefm_size = 11'h040;
				default: uefm_size = 11'h000;
			endcase
		end
	endfunction : uefm_size
endpackage : uefm_pkg

// [design/uefm_store.sv]
`timescale 1ns/100ps
module uefm_store (
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Port A
	input  wire logic                        a_we,
	input  wire logic [uefm_pkg::AW-1:0]     a_addr,
	input  wire logic [uefm_pkg::DW-1:0]     a_wdata,
	output logic      [uefm_pkg::DW-1:0]     a_rdata,
	// Port B
	input  wire logic                        b_we,
	input  wire logic [uefm_pkg::AW-1:0]     b_addr,
	input  wire logic [uefm_pkg::DW-1:0]     b_wdata,
	output logic      [uefm_pkg::DW-1:0]     b_rdata
);
	logic [uefm_pkg::DW-1:0] mem [uefm_pkg::DEPTH];

	always_ff @(posedge sys_clk) begin
		if (a_we)
			mem[a_addr] <= a_wdata;
		if (b_we)
			mem[b_addr] <= b_wdata;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			a_rdata <= '0;
			b_rdata <= '0;
		end else begin
			a_rdata <= mem[a_addr];
			b_rdata <= mem[b_addr];
		end
	end
endmodule : uefm_store

// [design/uefm_alloc.sv]
`timescale 1ns/100ps
module uefm_alloc (
	// Configuration of all slots
	input  wire logic [uefm_pkg::NSLOT*uefm_pkg::CW-1:0] cfg_flat,
	// Placement
	output logic      [uefm_pkg::NSLOT*uefm_pkg::AW-1:0] base_flat,
	output logic      [uefm_pkg::NSLOT*uefm_pkg::LW-1:0] size_flat,
	output logic      [uefm_pkg::PW-1:0]                 total,
	output logic                                         overflow
);
	localparam int PW = uefm_pkg::PW;
	localparam int AW = uefm_pkg::AW;
	localparam int LW = uefm_pkg::LW;
	localparam int CW = uefm_pkg::CW;

	logic [PW-1:0] sum [uefm_pkg::NSLOT+1];
	assign sum[0] = '0;

	// Prefix sum of physical sizes places every buffer without firmware help
	for (genvar i = 0; i < uefm_pkg::NSLOT; i++) begin : g_slot
		wire [LW-1:0] sz = uefm_pkg::uefm_size(cfg_flat[i*CW +: CW]);  // [RULE5] [RULE6] [RULE7]
		wire [PW-1:0] phys = (i >= uefm_pkg::CTRL_SLOTS) ? PW'({sz, 1'b0}) : PW'(sz); // [RULE9] [RULE1]
		assign sum[i+1] = sum[i] + phys;  // [RULE11]
		assign base_flat[i*AW +: AW] = sum[i][AW-1:0];
		assign size_flat[i*LW +: LW] = sz;
	end

	assign total    = sum[uefm_pkg::NSLOT];
	assign overflow = total > PW'(uefm_pkg::DEPTH);  // [RULE3]
endmodule : uefm_alloc

// [design/uefm_top.sv]
// What this block does
// RULE1: Endpoint zero is two fixed 64-byte control buffers, always on, single-buffered.
// RULE2: Fourteen endpoints set size, type and direction via own config.
// RULE3: Firmware keeps physical storage of enabled endpoints within 2462 bytes.
// RULE4: A packet never exceeds its endpoint's configured buffer size.
// RULE5: Only enabled endpoints get storage; disabled ones get zero bytes.
// RULE6: Allocation uses enable, size code, iso bit; last two only if enabled.
// RULE7: Size codes give 8..64 bytes, or 16..1023 when isochronous.
// RULE8: No allocation change while any enabled buffer holds data.
// RULE9: Double-buffered endpoints take twice logical size, managed by hardware.
// RULE10: Set Interface makes firmware write all sixteen configs in order.
// RULE11: Storage is placed automatically after config writes.
// RULE12: Firmware sends empty packet on good config, else stalls control transmit.
// RULE13: Any reset clears every config, leaving only control enabled.
// RULE14: Configuration counts as valid only after enumeration.
// RULE15: Each sent or received packet sets that endpoint's event flag.
// RULE16: Status read clears the event flag and shows buffer state.
// RULE17: Receive buffer read yields length first, then data.
// RULE18: After reading, buffer clear frees the endpoint.
// RULE19: Transmit data is written, then validated; only validated data is sent.
// RULE20: Direction bit chooses transmit or receive on each endpoint.
// RULE21: SETUP flushes control transmit and locks validate and clear until acknowledged.
// RULE22: Full receive or unvalidated transmit buffers answer tokens with NAK.
`timescale 1ns/100ps
module uefm_top (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         usb_bus_reset,
	// Avalon-MM register slave
	input  wire logic [uefm_pkg::RA_W-1:0]    avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	output logic      [31:0]                  avs_readdata,
	output logic                              avs_waitrequest,
	// Serial protocol engine, packet receive
	input  wire logic                         sie_rx_start,
	input  wire logic                         sie_rx_setup,
	input  wire logic [uefm_pkg::SW-1:0]      sie_slot,
	input  wire logic                         sie_rx_valid,
	input  wire logic [uefm_pkg::DW-1:0]      sie_rx_data,
	input  wire logic                         sie_rx_end,
	// Serial protocol engine, packet transmit
	input  wire logic                         sie_tx_start,
	output logic                              sie_tx_valid,
	output logic      [uefm_pkg::DW-1:0]      sie_tx_data,
	output logic                              sie_tx_last,
	output logic                              sie_tx_empty,
	// Serial protocol engine, token handshake
	input  wire logic [uefm_pkg::SW-1:0]      sie_token_slot,
	input  wire logic                         sie_token_in,
	output logic                              sie_nak
);
	localparam int NS = uefm_pkg::NSLOT;
	localparam int SW = uefm_pkg::SW;
	localparam int BI = uefm_pkg::BI;
	localparam int AW = uefm_pkg::AW;
	localparam int LW = uefm_pkg::LW;
	localparam int CW = uefm_pkg::CW;
	localparam int BW = 32;

	function automatic logic [AW-1:0] buf_addr(input logic [AW-1:0] base,
		input logic [LW-1:0] size, input logic bank, input logic [LW-1:0] ptr);
		logic [AW-1:0] off;
		off = bank ? AW'(size) : '0;
		buf_addr = base + off + AW'(ptr);
	endfunction : buf_addr

	function automatic logic [NS-1:0] one_hot(input logic [SW-1:0] slot);
		one_hot = NS'(1) << slot;
	endfunction : one_hot

	logic [CW-1:0]    cfg [NS];
	logic [AW-1:0]    base_a [NS];
	logic [LW-1:0]    size_a [NS];
	logic [LW-1:0]    len_mem [2*NS];
	wire [NS*CW-1:0]  cfg_flat;
	wire [NS*AW-1:0]  base_flat;
	wire [NS*LW-1:0]  size_flat;
	wire [uefm_pkg::PW-1:0] total;
	wire              overflow;
	logic [2*NS-1:0]  full;
	logic [NS-1:0]    sie_bank;
	logic [NS-1:0]    cpu_bank;
	logic [NS-1:0]    flag;
	logic [1:0]       lock;
	logic             ack_q;
	logic [SW-1:0]    cpu_sel;
	logic [LW-1:0]    cpu_ptr;
	logic             len_phase;
	uefm_pkg::uefm_state_e state;
	uefm_pkg::uefm_state_e next_state;
	logic [SW-1:0]    cur;
	logic [LW-1:0]    ptr;
	logic             accept;
	wire [uefm_pkg::DW-1:0] a_rdata;
	wire [uefm_pkg::DW-1:0] b_rdata;

	// Every access waits one cycle so store read data is ready
	wire             acc     = avs_read | avs_write;
	wire             rd_done = avs_read & ack_q;
	wire             wr_done = avs_write & ack_q;
	wire [1:0]       win     = avs_address[uefm_pkg::RA_W-1:uefm_pkg::WIN_LSB];
	wire [SW-1:0]    a_slot  = avs_address[uefm_pkg::SLOT_LSB +: SW];
	wire             hit_cfg  = win == uefm_pkg::WIN_CFG;
	wire             hit_stat = win == uefm_pkg::WIN_STAT;
	wire             hit_data = avs_address == uefm_pkg::REG_DATA;
	assign avs_waitrequest = acc & ~ack_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= acc & ~ack_q;
	end

	// Control slots are constants and ignore writes
	for (genvar i = 0; i < NS; i++) begin : g_cfg
		localparam logic [CW-1:0] INIT = (i == 0) ? uefm_pkg::CTRL_OUT_CFG :
			(i == 1) ? uefm_pkg::CTRL_IN_CFG : uefm_pkg::CFG_RST;
		if (i < uefm_pkg::CTRL_SLOTS) begin : g_fix
			assign cfg[i] = INIT;  // [RULE1]
		end else begin : g_prog
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					cfg[i] <= INIT;
				else if (usb_bus_reset)
					cfg[i] <= INIT;  // [RULE13]
				else if (wr_done && hit_cfg && a_slot == SW'(i))
					cfg[i] <= avs_writedata[CW-1:0];  // [RULE2]
			end
		end
		assign cfg_flat[i*CW +: CW] = cfg[i];
		assign base_a[i] = base_flat[i*AW +: AW];
		assign size_a[i] = size_flat[i*LW +: LW];
	end

	uefm_alloc u_alloc (
		.cfg_flat  (cfg_flat),
		.base_flat (base_flat),
		.size_flat (size_flat),
		.total     (total),
		.overflow  (overflow)
	);

	// Firmware command port
	wire             cmd_go   = wr_done & (avs_address == uefm_pkg::REG_CMD);
	wire [3:0]       cmd_op   = avs_writedata[uefm_pkg::CMD_OP +: 4];
	wire [SW-1:0]    cmd_slot = avs_writedata[SW-1:0];
	wire [BI-1:0]    cmd_bi   = {cmd_slot, cpu_bank[cmd_slot]};
	wire             cmd_ctrl = cmd_slot < SW'(uefm_pkg::CTRL_SLOTS);
	wire             cmd_lock = cmd_ctrl & lock[cmd_slot[0]];
	wire             do_clear = cmd_go & (cmd_op == uefm_pkg::OP_CLEAR) & ~cmd_lock;  // [RULE21]
	wire             do_valid = cmd_go & (cmd_op == uefm_pkg::OP_VALID) & ~cmd_lock;  // [RULE21]
	wire             do_open  = cmd_go & ((cmd_op == uefm_pkg::OP_READ) |
		(cmd_op == uefm_pkg::OP_WRITE));
	wire             do_ack   = cmd_go & (cmd_op == uefm_pkg::OP_ACK) & cmd_ctrl;
	wire [BI-1:0]    ci       = {cpu_sel, cpu_bank[cpu_sel]};
	wire             cpu_fits = cpu_ptr < size_a[cpu_sel];
	wire             data_go  = (rd_done | wr_done) & hit_data;
	wire             b_we     = wr_done & hit_data & ~len_phase & cpu_fits;  // [RULE4]
	wire [AW-1:0]    b_addr   = buf_addr(base_a[cpu_sel], size_a[cpu_sel], cpu_bank[cpu_sel],
		cpu_ptr);
	wire [LW-1:0]    wr_len   = (avs_writedata[LW-1:0] > size_a[cpu_sel]) ? size_a[cpu_sel] :
		avs_writedata[LW-1:0];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_sel   <= '0;
			cpu_ptr   <= '0;
			len_phase <= 1'b0;
		end else if (do_open) begin
			cpu_sel   <= cmd_slot;
			cpu_ptr   <= '0;
			len_phase <= 1'b1;
		end else if (data_go && len_phase) begin
			len_phase <= 1'b0;  // [RULE17]
		end else if (data_go && cpu_fits) begin
			cpu_ptr   <= cpu_ptr + 1'b1;
		end
	end

	// Packet engine facing the serial protocol engine
	wire [BI-1:0]    si      = {cur, sie_bank[cur]};
	wire [BI-1:0]    ni      = {sie_slot, sie_bank[sie_slot]};
	wire             setup0  = sie_rx_setup & (sie_slot == uefm_pkg::SLOT_CTRL_OUT);
	wire             rx_ok   = setup0 | (cfg[sie_slot][uefm_pkg::CFG_EN] &
		~cfg[sie_slot][uefm_pkg::CFG_DIR] & ~full[ni]);  // [RULE18] [RULE20]
	wire             tx_ok   = cfg[sie_slot][uefm_pkg::CFG_EN] &
		cfg[sie_slot][uefm_pkg::CFG_DIR] & full[ni];  // [RULE19] [RULE20]
	wire             idle    = state == uefm_pkg::S_IDLE;
	wire             setup_go = idle & sie_rx_start & setup0;
	wire             fits    = ptr < size_a[cur];
	wire             a_we    = (state == uefm_pkg::S_RX) & sie_rx_valid & accept & fits;  // [RULE4]
	wire [AW-1:0]    a_addr  = buf_addr(base_a[cur], size_a[cur], sie_bank[cur], ptr);
	wire             rx_done = (state == uefm_pkg::S_RX) & sie_rx_end & accept;
	wire             tx_last = (state == uefm_pkg::S_TX_OUT) & (LW'(ptr + 1'b1) == len_mem[si]);
	wire             tx_zlp  = idle & ~sie_rx_start & sie_tx_start & tx_ok & (len_mem[ni] == '0);
	wire             ev      = rx_done | tx_last | tx_zlp;
	wire [SW-1:0]    ev_slot = tx_zlp ? sie_slot : cur;
	wire [BI-1:0]    ev_bi   = tx_zlp ? ni : si;
	wire             ev_dbl  = ev_slot >= SW'(uefm_pkg::CTRL_SLOTS);

	always_comb begin
		next_state = state;
		case (state)
			uefm_pkg::S_IDLE: begin
				if (sie_rx_start)
					next_state = uefm_pkg::S_RX;
				else if (sie_tx_start && tx_ok && len_mem[ni] != '0)
					next_state = uefm_pkg::S_TX_RD;
			end
			uefm_pkg::S_RX: begin
				if (sie_rx_end)
					next_state = uefm_pkg::S_IDLE;
			end
			uefm_pkg::S_TX_RD:
				next_state = uefm_pkg::S_TX_OUT;
			uefm_pkg::S_TX_OUT: begin
				next_state = tx_last ? uefm_pkg::S_IDLE : uefm_pkg::S_TX_RD;
			end
			default:
				next_state = uefm_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state  <= uefm_pkg::S_IDLE;
			cur    <= '0;
			ptr    <= '0;
			accept <= 1'b0;
		end else if (usb_bus_reset) begin
			state  <= uefm_pkg::S_IDLE;
			accept <= 1'b0;
		end else begin
			state <= next_state;
			if (idle && (sie_rx_start || sie_tx_start)) begin
				cur    <= sie_slot;
				ptr    <= '0;
				accept <= sie_rx_start & rx_ok;
			end else if ((a_we) || (state == uefm_pkg::S_TX_OUT)) begin
				ptr    <= ptr + 1'b1;
			end
		end
	end

	// A received packet keeps only what fitted
	always_ff @(posedge sys_clk) begin
		if (wr_done && hit_data && len_phase)
			len_mem[ci] <= wr_len;  // [RULE19] [RULE4]
		if (rx_done)
			len_mem[si] <= ptr;
	end

	// Engine events come last so they win over commands
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			full <= '0;
		end else if (usb_bus_reset) begin
			full <= '0;
		end else begin
			if (do_clear)
				full[cmd_bi] <= 1'b0;  // [RULE18]
			if (do_valid)
				full[cmd_bi] <= 1'b1;  // [RULE19]
			if (setup_go)
				full[uefm_pkg::CTRL_IN_BI] <= 1'b0;  // [RULE21]
			if (rx_done)
				full[si] <= 1'b1;
			if (tx_last || tx_zlp)
				full[ev_bi] <= 1'b0;
		end
	end

	// Banks flip only on double-buffered slots
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sie_bank <= '0;
			cpu_bank <= '0;
		end else if (usb_bus_reset) begin
			sie_bank <= '0;
			cpu_bank <= '0;
		end else begin
			if (ev && ev_dbl)
				sie_bank[ev_slot] <= ~sie_bank[ev_slot];  // [RULE9]
			if ((do_clear || do_valid) && !cmd_ctrl)
				cpu_bank[cmd_slot] <= ~cpu_bank[cmd_slot];  // [RULE9]
		end
	end

	// A new SETUP outranks an acknowledge in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lock <= '0;
		end else if (usb_bus_reset) begin
			lock <= '0;
		end else if (setup_go) begin
			lock <= 2'h3;  // [RULE21]
		end else if (do_ack) begin
			lock[cmd_slot[0]] <= 1'b0;
		end
	end

	// Flag set wins over the status-read clear
	wire [NS-1:0] flag_set = ev ? one_hot(ev_slot) : '0;  // [RULE15]
	wire [NS-1:0] flag_clr = (rd_done && hit_stat) ? one_hot(a_slot) : '0;  // [RULE16]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			flag <= '0;
		else if (usb_bus_reset)
			flag <= '0;
		else
			flag <= (flag & ~flag_clr) | flag_set;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sie_tx_empty <= 1'b0;
		else
			sie_tx_empty <= tx_zlp;
	end

	uefm_store u_store (
		.sys_clk (sys_clk),
		.rst     (rst),
		.a_we    (a_we),
		.a_addr  (a_addr),
		.a_wdata (sie_rx_data),
		.a_rdata (a_rdata),
		.b_we    (b_we),
		.b_addr  (b_addr),
		.b_wdata (avs_writedata[uefm_pkg::DW-1:0]),
		.b_rdata (b_rdata)
	);

	assign sie_tx_valid = state == uefm_pkg::S_TX_OUT;
	assign sie_tx_data  = a_rdata;
	assign sie_tx_last  = tx_last;

	// A locked control transmit stays empty and so NAKs
	wire [BI-1:0] tbi    = {sie_token_slot, sie_bank[sie_token_slot]};
	wire          tok_ok = cfg[sie_token_slot][uefm_pkg::CFG_EN] &
		(cfg[sie_token_slot][uefm_pkg::CFG_DIR] == sie_token_in) &
		(sie_token_in ? full[tbi] : ~full[tbi]);
	assign sie_nak = ~tok_ok;  // [RULE22] [RULE20]

	// Read mux
	wire          slock = (a_slot < SW'(uefm_pkg::CTRL_SLOTS)) & lock[a_slot[0]];
	wire [5:0]    stat  = {slock, cfg[a_slot][uefm_pkg::CFG_DIR], cfg[a_slot][uefm_pkg::CFG_EN],
		full[{a_slot, 1'b1}], full[{a_slot, 1'b0}], flag[a_slot]};  // [RULE16]
	wire [BW-1:0] rd_mux =
		hit_cfg  ? BW'(cfg[a_slot]) :
		hit_stat ? BW'(stat) :
		(avs_address == uefm_pkg::REG_IRQ) ? BW'(flag) :
		hit_data ? (len_phase ? BW'(len_mem[ci]) : BW'(b_rdata)) :  // [RULE17]
		(avs_address == uefm_pkg::REG_ALLOC) ? {overflow, 15'h0000, total} : '0;
	assign avs_readdata = rd_done ? rd_mux : '0;
endmodule : uefm_top

// [verification/uefm_props.sv]
`timescale 1ns/100ps
module uefm_props (
	// Clock and reset
	input wire logic                      sys_clk,
	input wire logic                      rst,
	input wire logic                      usb_bus_reset,
	// Register bus
	input wire logic [uefm_pkg::RA_W-1:0] avs_address,
	input wire logic                      avs_read,
	input wire logic                      avs_write,
	input wire logic [31:0]               avs_readdata,
	input wire logic                      avs_waitrequest,
	// Transmit
	input wire logic                      sie_tx_start,
	input wire logic                      sie_tx_valid,
	input wire logic                      sie_tx_last,
	input wire logic                      sie_tx_empty
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire  rdone = avs_read && !avs_waitrequest;
	logic fresh;
	// Set until first write after reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst || usb_bus_reset)
			fresh <= 1'b1;
		else if (avs_write && !avs_waitrequest)
			fresh <= 1'b0;
	end
	sequence tx_mid; sie_tx_valid && !sie_tx_last; endsequence
	sequence tx_next; !sie_tx_valid ##1 sie_tx_valid; endsequence
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("long bus wait");
	data_idle_a: assert property (!rdone |-> avs_readdata == 32'h0)
		else $error("stray read data");
	ctrl_on_a: assert property (rdone && avs_address[7:3] == 5'h10 |-> avs_readdata[3])
		else $error("control disabled");
	cfg_clear_a: assert property (fresh && rdone && avs_address inside {[8'h08:8'h3C]}
		|-> avs_readdata == 32'h0)
		else $error("config not cleared");
	alloc_base_a: assert property (fresh && rdone && avs_address == 8'h4C
		|-> avs_readdata == 32'h80)
		else $error("disabled storage");
	tx_last_a: assert property (sie_tx_last |-> sie_tx_valid)
		else $error("last without byte");
	tx_pace_a: assert property (tx_mid |=> tx_next)
		else $error("bad tx pacing");
	empty_src_a: assert property (sie_tx_empty |-> $past(sie_tx_start))
		else $error("stray empty");
endmodule : uefm_props
bind uefm_top uefm_props i_props (.sys_clk, .rst, .usb_bus_reset, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .sie_tx_start, .sie_tx_valid, .sie_tx_last,
	.sie_tx_empty);

// [verification/uefm_sie_model.sv]
`timescale 1ns/100ps
module uefm_sie_model (
	// Clock
	input  wire logic                    sys_clk,
	// Receive
	output logic                         sie_rx_start,
	output logic                         sie_rx_setup,
	output logic [uefm_pkg::SW-1:0]      sie_slot,
	output logic                         sie_rx_valid,
	output logic [uefm_pkg::DW-1:0]      sie_rx_data,
	output logic                         sie_rx_end,
	// Transmit
	output logic                         sie_tx_start,
	input  wire logic                    sie_tx_valid,
	input  wire logic [uefm_pkg::DW-1:0] sie_tx_data,
	input  wire logic                    sie_tx_last,
	input  wire logic                    sie_tx_empty
);
	logic [7:0] got[$];
	logic       got_empty;
	initial begin
		{sie_rx_start, sie_rx_setup, sie_rx_valid, sie_rx_end, sie_tx_start, sie_slot,
			sie_rx_data} = 17'h00000;
	end
	task automatic rx_pkt(input logic [3:0] s, input int n, input logic stp, input logic [7:0] b);
		sie_slot <= s;
		sie_rx_setup <= stp;
		sie_rx_start <= 1'b1;
		@(posedge sys_clk);
		sie_rx_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			sie_rx_valid <= 1'b1;
			sie_rx_data <= b + 8'(i);
			@(posedge sys_clk);
		end
		// Idle data inverted so stale bytes stand out
		sie_rx_valid <= 1'b0;
		sie_rx_data <= ~sie_rx_data;
		sie_rx_end <= 1'b1;
		@(posedge sys_clk);
		sie_rx_end <= 1'b0;
		@(posedge sys_clk);
	endtask : rx_pkt
	task automatic tx_pkt(input logic [3:0] s);
		got.delete();
		got_empty = 1'b0;
		sie_slot <= s;
		sie_tx_start <= 1'b1;
		@(posedge sys_clk);
		sie_tx_start <= 1'b0;
		for (int i = 0; i < 80; i++) begin
			@(posedge sys_clk);
			got_empty |= sie_tx_empty === 1'b1;
			if (sie_tx_valid === 1'b1)
				got.push_back(sie_tx_data);
			if (sie_tx_valid === 1'b1 && sie_tx_last === 1'b1)
				break;
		end
	endtask : tx_pkt
endmodule : uefm_sie_model

// [verification/test_usb_endpoint_fifo_manager.sv]
`timescale 1ns/100ps
module test_usb_endpoint_fifo_manager;
	logic        sys_clk = 1'b0, rst = 1'b1, usb_bus_reset = 1'b0;
	logic        avs_read = 1'b0, avs_write = 1'b0, sie_token_in = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  sie_token_slot = 4'h0;
	wire [31:0] avs_readdata;
	wire [7:0]  sie_rx_data, sie_tx_data;
	wire [3:0]  sie_slot;
	wire avs_waitrequest, sie_rx_start, sie_rx_setup, sie_rx_valid, sie_rx_end, sie_nak;
	wire sie_tx_start, sie_tx_valid, sie_tx_last, sie_tx_empty;
	int          n_errors = 0;
	int          samples_checked = 0;
	logic [31:0] rnd = 32'hB043;
	logic [31:0] q;
	logic [7:0]  cfg[16];
	uefm_top i_dut (.sys_clk, .rst, .usb_bus_reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .sie_rx_start, .sie_rx_setup, .sie_slot,
		.sie_rx_valid, .sie_rx_data, .sie_rx_end, .sie_tx_start, .sie_tx_valid, .sie_tx_data,
		.sie_tx_last, .sie_tx_empty, .sie_token_slot, .sie_token_in, .sie_nak);
	uefm_sie_model i_sie (.sys_clk, .sie_rx_start, .sie_rx_setup, .sie_slot, .sie_rx_valid,
		.sie_rx_data, .sie_rx_end, .sie_tx_start, .sie_tx_valid, .sie_tx_data, .sie_tx_last,
		.sie_tx_empty);
	always #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic int exp_sz(input logic [7:0] c);
		int iso_t[16] = '{16, 32, 48, 64, 96, 128, 160, 192, 256, 320, 384, 512, 640, 768, 896, 1023};
		if (!c[0])
			return 0;
		if (c[2])
			return iso_t[c[7:4]];
		return (c[7:4] < 4) ? (8 << c[7:4]) : 0;
	endfunction : exp_sz
	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				n_errors++;
				end_sim();
			end
			@(posedge sys_clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask : rchk
	task automatic cmd(input logic [3:0] op, input logic [3:0] s);
		bus(1'b1, uefm_pkg::REG_CMD, {24'h0, op, s});
	endtask : cmd
	task automatic cfg_all();
		int t = 128;
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, 8'(4 * i), {24'h0, cfg[i]});
			t += (i < 2) ? 0 : 2 * exp_sz(cfg[i]);
		end
		rchk("alloc", uefm_pkg::REG_ALLOC, 32'hFFFFFFFF, 32'(t));
	endtask : cfg_all
	task automatic rd_pkt(input logic [3:0] s, input int n, input logic [7:0] b);
		cmd(uefm_pkg::OP_READ, s);
		rchk("rx length", uefm_pkg::REG_DATA, 32'h7FF, 32'(n));
		for (int i = 0; i < n; i++)
			rchk("rx byte", uefm_pkg::REG_DATA, 32'hFF, {24'h0, b + 8'(i)});
		cmd(uefm_pkg::OP_CLEAR, s);
	endtask : rd_pkt
	initial begin
		int n;
		logic [7:0] b;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rchk("cfg reset", 8'h08, 32'hFF, 32'h0);
		rchk("alloc reset", uefm_pkg::REG_ALLOC, 32'hFFFF, 32'h80);
		rchk("unmapped", 8'h60, 32'hFFFFFFFF, 32'h0);
		repeat (4) begin
			n = 128;
			for (int i = 0; i < 16; i++) begin
				rnd = lfsr(rnd);
				cfg[i] = rnd[7:0];
				if (i < 2 || n + 2 * exp_sz(cfg[i]) > 2462)
					cfg[i][0] = 1'b0;
				n += 2 * exp_sz(cfg[i]);
			end
			cfg_all();
		end
		foreach (cfg[i])
			cfg[i] = 8'h00;
		cfg[2] = 8'h01;
		cfg[3] = 8'h13;
		for (int k = 0; k < 24; k++) begin
			cfg[4] = (k < 16) ? {4'(k), 4'h5} : {4'(k - 16), 4'h1};
			cfg_all();
		end
		cfg[4] = 8'h00;
		cfg_all();
		rnd = lfsr(rnd);
		b = rnd[7:0];
		i_sie.rx_pkt(4'h2, 10, 1'b0, b);
		i_sie.rx_pkt(4'h2, 3, 1'b0, b + 8'h40);
		i_sie.rx_pkt(4'h2, 5, 1'b0, b + 8'h80);
		rchk("rx flag", uefm_pkg::REG_IRQ, 32'h4, 32'h4);
		rchk("rx status", 8'h88, 32'h3F, 32'h0F);
		rchk("flag cleared", uefm_pkg::REG_IRQ, 32'h4, 32'h0);
		sie_token_slot <= 4'h2;
		@(posedge sys_clk);
		chk("nak full", 32'h1, 32'(sie_nak));
		rd_pkt(4'h2, 8, b);
		rd_pkt(4'h2, 3, b + 8'h40);
		rchk("rx freed", 8'h88, 32'h6, 32'h0);
		sie_token_slot <= 4'h3;
		sie_token_in <= 1'b1;
		@(posedge sys_clk);
		chk("nak unvalidated", 32'h1, 32'(sie_nak));
		i_sie.tx_pkt(4'h3);
		chk("tx early", 32'h0, i_sie.got.size());
		rnd = lfsr(rnd);
		n = 1 + rnd[3:0];
		cmd(uefm_pkg::OP_WRITE, 4'h3);
		bus(1'b1, uefm_pkg::REG_DATA, 32'(n));
		for (int i = 0; i < n; i++)
			bus(1'b1, uefm_pkg::REG_DATA, {24'h0, b + 8'(i)});
		cmd(uefm_pkg::OP_VALID, 4'h3);
		chk("nak validated", 32'h0, 32'(sie_nak));
		i_sie.tx_pkt(4'h3);
		chk("tx count", 32'(n), i_sie.got.size());
		foreach (i_sie.got[i])
			chk("tx byte", {24'h0, b + 8'(i)}, {24'h0, i_sie.got[i]});
		rchk("tx flag", uefm_pkg::REG_IRQ, 32'h8, 32'h8);
		i_sie.rx_pkt(4'h0, 8, 1'b1, b);
		rchk("lock out", 8'h80, 32'h20, 32'h20);
		rchk("lock in", 8'h84, 32'h20, 32'h20);
		cmd(uefm_pkg::OP_CLEAR, 4'h0);
		rchk("clear locked", 8'h80, 32'h2, 32'h2);
		cmd(uefm_pkg::OP_ACK, 4'h0);
		cmd(uefm_pkg::OP_ACK, 4'h1);
		rchk("unlocked", 8'h84, 32'h20, 32'h0);
		rd_pkt(4'h0, 8, b);
		rchk("setup freed", 8'h80, 32'h2, 32'h0);
		cmd(uefm_pkg::OP_WRITE, 4'h1);
		bus(1'b1, uefm_pkg::REG_DATA, 32'h0);
		cmd(uefm_pkg::OP_VALID, 4'h1);
		i_sie.tx_pkt(4'h1);
		chk("empty packet", 32'h1, 32'(i_sie.got_empty));
		usb_bus_reset <= 1'b1;
		@(posedge sys_clk);
		usb_bus_reset <= 1'b0;
		@(posedge sys_clk);
		rchk("cfg bus reset", 8'h0C, 32'hFF, 32'h0);
		rchk("alloc bus reset", uefm_pkg::REG_ALLOC, 32'hFFFF, 32'h80);
		end_sim();
	end
endmodule : test_usb_endpoint_fifo_manager
